/* File: hw/afc_pkg.sv */
// package of constants for the accelerometer filter chain
`default_nettype none
package afc_pkg;
    // register offsets and fields
    localparam logic [7:0] AFC_FILTER_SETTINGS_OFFSET = 8'h28;
    localparam logic [7:0] AFC_SELF_TEST_CONTROL_OFFSET = 8'h2e;
    localparam int AFC_HPF_LSB = 4;
    localparam int AFC_RATE_LSB = 0;
    localparam int AFC_ST_ENABLE_BIT = 0;
    localparam int AFC_ST_FORCE_BIT = 1;
    localparam logic [7:0] AFC_FILTER_SETTINGS_RESET = 8'h00;
    localparam logic [7:0] AFC_SELF_TEST_CONTROL_RESET = 8'h00;
    // converter sample width
    localparam int AFC_SAMPLE_W = 20;
    // first stage decimation factor from converter rate to the top output rate
    localparam int AFC_DEC1_FACTOR = 4;
    localparam int AFC_DEC1_LOG2 = 2;
    // highest rate code selects divide by 1024
    localparam logic [3:0] AFC_RATE_MAX_CODE = 4'ha;
    // overrange pause time in microseconds and its cycle count at 10 MHz
    localparam int AFC_CLK_HZ = 10000000;
    localparam int AFC_OVERRANGE_PAUSE_US = 500;
    localparam int AFC_OVERRANGE_PAUSE_CYC = AFC_OVERRANGE_PAUSE_US * (AFC_CLK_HZ / 1000000);
    // self test stimulus offset added on the z axis
    localparam logic [19:0] AFC_ST_RESPONSE = 20'h00400;
    // interpolation: steps of 1/64, 63 sub-samples per output sample
    localparam int AFC_INTERP_LOG2 = 6;
endpackage
`default_nettype wire

/* File: hw/afc_decimator.sv */
// averaging decimator stage with selectable power of two factor
`default_nettype none
module afc_decimator
    import afc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // sample input
    input wire logic i_valid,
    input wire logic signed [19:0] i_data,
    input wire logic [3:0] i_log2,
    // sample output
    output logic o_valid,
    output logic signed [19:0] o_data
);
    logic signed [31:0] acc_reg;
    logic [10:0] cnt_reg;
    logic [10:0] last;
    logic signed [31:0] sum;

    assign last = 11'((32'd1 << i_log2) - 32'd1);
    assign sum = acc_reg + 32'(i_data);

    // boxcar average gives the low pass response before the rate drop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            o_valid <= 1'b0;
            o_data <= '0;
        end else begin
            o_valid <= 1'b0;
            if (i_valid) begin
                if (cnt_reg >= last) begin
                    cnt_reg <= '0;
                    acc_reg <= '0;
                    o_valid <= 1'b1;
                    o_data <= 20'(sum >>> i_log2);
                end else begin
                    cnt_reg <= cnt_reg + 11'd1;
                    acc_reg <= sum;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/afc_highpass.sv */
// first order high pass via leaky dc tracker, shift sets the corner
`default_nettype none
module afc_highpass
    import afc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // sample input and corner code
    input wire logic i_valid,
    input wire logic signed [19:0] i_data,
    input wire logic [2:0] i_corner,
    // sample output
    output logic o_valid,
    output logic signed [19:0] o_data
);
    logic signed [39:0] dc_reg;
    logic signed [39:0] err;
    logic [4:0] shift;

    // each code lowers the corner by about four times
    assign shift = 5'(2 * i_corner + 3);
    assign err = (40'(i_data) <<< 16) - dc_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dc_reg <= '0;
            o_valid <= 1'b0;
            o_data <= '0;
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                if (i_corner == 3'h0) begin
                    dc_reg <= '0;
                    o_data <= i_data;
                end else begin
                    dc_reg <= dc_reg + (err >>> shift);
                    o_data <= 20'(err >>> 16);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: hw/afc_filter_chain.sv */
// accelerometer digital chain: decimation, high pass, interpolation, self test
`default_nettype none
// Overview of operation
// - overrange drives outputs toward zero, still buffered
// - overrange stops drive clocks for fixed pause
// - enable bit enters self-test mode
// - force bit with enable shifts z-axis output
// - self-test bits live in register 0x2e
// - converter samples are twenty bits wide
// - rates 4 kHz down to 3.906 Hz
// - first stage fixed decimation, quarter-rate low pass
// - second stage bypassed at top rate
// - high pass inactive after reset
// - three-bit corner field bits 6:4 of 0x28
// - corner code zero disables high pass
// - power-up defaults: top rate, high pass off
// - interpolator upsamples, syncs to external strobe
// - delay counted from converter to readable output
module afc_filter_chain
    import afc_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // converter input, one axis sample per strobe
    input wire logic i_adc_valid,
    input wire logic [1:0] i_adc_axis,
    input wire logic signed [19:0] i_adc_data,
    input wire logic i_overrange,
    input wire logic i_ext_sync,
    // sensor drive and self test
    output logic o_drive_clk_en,
    output logic o_self_test_mode,
    output logic o_self_test_force,
    // filtered output toward the sample buffer
    output logic o_smp_valid,
    output logic [1:0] o_smp_axis,
    output logic signed [19:0] o_smp_data,
    output logic o_interp_valid,
    output logic signed [19:0] o_interp_data
);
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [7:0] filter_settings_reg;
    logic [7:0] self_test_control_reg;
    logic [$clog2(AFC_OVERRANGE_PAUSE_CYC+1)-1:0] pause_cnt_reg;
    logic pausing;
    logic signed [19:0] conv_data;
    logic [2:0] corner;
    logic [3:0] rate_code;
    logic [1:0] axis_reg;
    logic signed [19:0] chain_data;
    logic chain_valid;
    logic signed [19:0] prev_reg;
    logic signed [19:0] step_reg;
    logic [AFC_INTERP_LOG2-1:0] phase_reg;
    logic signed [19:0] interp_acc_reg;

    function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // reset release through two flops
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    assign corner = filter_settings_reg[AFC_HPF_LSB +: 3];
    assign rate_code = (filter_settings_reg[AFC_RATE_LSB +: 4] > AFC_RATE_MAX_CODE) ?
        AFC_RATE_MAX_CODE : filter_settings_reg[AFC_RATE_LSB +: 4];

    // registers; reset gives top rate and no high pass
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            filter_settings_reg <= AFC_FILTER_SETTINGS_RESET;
            self_test_control_reg <= AFC_SELF_TEST_CONTROL_RESET;
        end else if (i_reg_wr) begin
            if (hits(i_reg_addr, AFC_FILTER_SETTINGS_OFFSET))
                filter_settings_reg <= {1'b0, i_reg_wdata[6:0]};
            if (hits(i_reg_addr, AFC_SELF_TEST_CONTROL_OFFSET))
                self_test_control_reg <= {6'h00, i_reg_wdata[1:0]};
        end
    end

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            if (hits(i_reg_addr, AFC_FILTER_SETTINGS_OFFSET))
                o_reg_rdata <= filter_settings_reg;
            else if (hits(i_reg_addr, AFC_SELF_TEST_CONTROL_OFFSET))
                o_reg_rdata <= self_test_control_reg;
            else
                o_reg_rdata <= 8'h00;
        end
    end

    // self test outputs; force only acts in self test mode
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_self_test_mode <= 1'b0;
            o_self_test_force <= 1'b0;
        end else begin
            o_self_test_mode <= self_test_control_reg[AFC_ST_ENABLE_BIT];
            o_self_test_force <= self_test_control_reg[AFC_ST_ENABLE_BIT] &
                self_test_control_reg[AFC_ST_FORCE_BIT];
        end
    end

    // overrange pause: clocks off for the full interval; a hit during it only holds them off
    assign pausing = pause_cnt_reg != '0;
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pause_cnt_reg <= '0;
            o_drive_clk_en <= 1'b1;
        end else begin
            if (i_overrange && !pausing)
                pause_cnt_reg <= ($bits(pause_cnt_reg))'(AFC_OVERRANGE_PAUSE_CYC);
            else if (pausing)
                pause_cnt_reg <= pause_cnt_reg - ($bits(pause_cnt_reg))'(1);
            o_drive_clk_en <= !(i_overrange || (pause_cnt_reg > 1));
        end
    end

    // sensor with drive stopped reads zero; samples keep flowing on
    always_comb begin
        if (!o_drive_clk_en)
            conv_data = 20'sh00000;
        else if (o_self_test_force && i_adc_axis == 2'd2)
            conv_data = i_adc_data + AFC_ST_RESPONSE;
        else
            conv_data = i_adc_data;
    end

    // axes are time-multiplexed; one lane filters every axis, tagged with the latest axis
    logic d1_valid, d2_valid, hp_valid;
    logic signed [19:0] d1_data, d2_data, hp_data;
    logic [1:0] axis_d_reg;

    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg)
            axis_reg <= 2'd0;
        else if (i_adc_valid)
            axis_reg <= i_adc_axis;
    end

    afc_decimator u_dec1 (
        .i_clk(i_clk),
        .i_rst_n(rst_n_reg),
        .i_valid(i_adc_valid),
        .i_data(conv_data),
        .i_log2(4'(AFC_DEC1_LOG2)),
        .o_valid(d1_valid),
        .o_data(d1_data)
    );

    // code 0 is the top rate and bypasses the second stage
    afc_decimator u_dec2 (
        .i_clk(i_clk),
        .i_rst_n(rst_n_reg),
        .i_valid(d1_valid && rate_code != 4'h0),
        .i_data(d1_data),
        .i_log2(rate_code),
        .o_valid(d2_valid),
        .o_data(d2_data)
    );

    assign chain_valid = (rate_code == 4'h0) ? d1_valid : d2_valid;
    assign chain_data = (rate_code == 4'h0) ? d1_data : d2_data;

    // corner tracks the output rate since it updates once per output sample
    afc_highpass u_hpf (
        .i_clk(i_clk),
        .i_rst_n(rst_n_reg),
        .i_valid(chain_valid),
        .i_data(chain_data),
        .i_corner(corner),
        .o_valid(hp_valid),
        .o_data(hp_data)
    );

    // output sample becomes readable here, closing the delay path
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            o_smp_valid <= 1'b0;
            o_smp_axis <= 2'd0;
            o_smp_data <= '0;
            axis_d_reg <= 2'd0;
        end else begin
            axis_d_reg <= axis_reg;
            o_smp_valid <= hp_valid;
            if (hp_valid) begin
                o_smp_axis <= axis_d_reg;
                o_smp_data <= hp_data;
            end
        end
    end

    // linear interpolator: 63 steps of 1/64 between outputs, restarted by external sync
    always_ff @(posedge i_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            prev_reg <= '0;
            step_reg <= '0;
            phase_reg <= '0;
            interp_acc_reg <= '0;
            o_interp_valid <= 1'b0;
            o_interp_data <= '0;
        end else begin
            o_interp_valid <= 1'b0;
            // a sample that lands with a sync is still taken, so none is lost
            if (hp_valid) begin
                step_reg <= (hp_data - prev_reg) >>> AFC_INTERP_LOG2;
                prev_reg <= hp_data;
                interp_acc_reg <= prev_reg;
                phase_reg <= '0;
            end else if (i_ext_sync) begin
                phase_reg <= '0;
            end else if (phase_reg != '1) begin
                phase_reg <= phase_reg + AFC_INTERP_LOG2'(1);
                interp_acc_reg <= interp_acc_reg + step_reg;
                o_interp_valid <= 1'b1;
                o_interp_data <= interp_acc_reg + step_reg;
            end
            if (i_ext_sync) begin
                o_interp_valid <= 1'b1;
                o_interp_data <= interp_acc_reg;
            end
        end
    end

    // checks
    sequence overrange_hit_s;
        i_overrange && !pausing;
    endsequence

    property pause_starts_p;
        @(posedge i_clk) disable iff (!rst_n_reg)
        overrange_hit_s |=> !o_drive_clk_en [*8];
    endproperty
    drive_pause_a: assert property (pause_starts_p)
        else $error("drive clock not stopped after overrange");

    zero_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        !o_drive_clk_en && i_adc_valid |=>
        u_dec1.acc_reg == $past(u_dec1.acc_reg) || u_dec1.acc_reg == '0)
        else $error("paused sample not taken as zero");

    st_force_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        o_self_test_force |-> o_self_test_mode)
        else $error("force active without self test mode");

    st_mode_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        $rose(self_test_control_reg[AFC_ST_ENABLE_BIT]) |=> o_self_test_mode)
        else $error("self test mode did not follow enable");

    st_off_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        !self_test_control_reg[AFC_ST_ENABLE_BIT] |=>
        !o_self_test_mode && !o_self_test_force)
        else $error("self test outputs stayed on with enable low");

    st_write_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        i_reg_wr && i_reg_addr == AFC_SELF_TEST_CONTROL_OFFSET |=>
        self_test_control_reg[1:0] == $past(i_reg_wdata[1:0]))
        else $error("self test write not stored");

    rd_filter_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        i_reg_rd && hits(i_reg_addr, AFC_FILTER_SETTINGS_OFFSET) |=>
        o_reg_rdata == $past(filter_settings_reg))
        else $error("filter settings read back wrong");

    top_bypass_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        rate_code == 4'h0 |=> !d2_valid)
        else $error("second stage active at top rate");

    pause_end_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        pause_cnt_reg == ($bits(pause_cnt_reg))'(1) && !i_overrange |=> o_drive_clk_en)
        else $error("drive clock not resumed after pause");

    hpf_off_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        chain_valid && corner == 3'h0 |=> hp_valid && hp_data == $past(chain_data))
        else $error("high pass not bypassed with code zero");

    smp_follow_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        hp_valid |=> o_smp_valid && o_smp_data == $past(hp_data))
        else $error("filtered sample not presented");

    sync_out_a: assert property (@(posedge i_clk) disable iff (!rst_n_reg)
        i_ext_sync |=> o_interp_valid && o_interp_data == $past(interp_acc_reg))
        else $error("sync did not present the interpolated value");
endmodule
`default_nettype wire

/* File: testbench/afc_host_model.sv */
// host controller model driving the register strobe port
`default_nettype none
module afc_host_model
    import afc_pkg::*;
(
    // clock
    input wire logic i_clk,
    // register port toward the device
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [7:0] o_reg_addr,
    output logic [7:0] o_reg_wdata,
    input wire logic [7:0] i_reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_reg_wr <= 1'b0;
        o_reg_rd <= 1'b0;
        o_reg_addr <= 8'h00;
        o_reg_wdata <= 8'h00;
    end
    // released lines show the inverse, so stale values are never read as valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_reg_wr <= 1'b1;
        o_reg_addr <= a;
        o_reg_wdata <= d;
        @(posedge i_clk);
        o_reg_wr <= 1'b0;
        o_reg_addr <= ~a;
        o_reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_reg_rd <= 1'b1;
        o_reg_addr <= a;
        @(posedge i_clk);
        o_reg_rd <= 1'b0;
        o_reg_addr <= ~a;
        @(posedge i_clk);
        #1 d = i_reg_rdata;
    endtask
    // both self-test bits dropped once a measurement is over
    task automatic st_off();
        wr(AFC_SELF_TEST_CONTROL_OFFSET, 8'h00);
    endtask
endmodule
`default_nettype wire

/* File: testbench/test_accel_filter_chain_self_test.sv */
// self-checking bench for the accelerometer filter chain
`default_nettype none
module test_accel_filter_chain_self_test;
    timeunit 1ns;
    timeprecision 1ns;
    import afc_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic adc_valid = 1'b0;
    logic [1:0] adc_axis = 2'h0;
    logic signed [19:0] adc_data = 20'h00000;
    logic overrange = 1'b0;
    logic ext_sync = 1'b0;
    logic drive_en, st_mode, st_force, smp_valid, interp_valid;
    logic [1:0] smp_axis;
    logic signed [19:0] smp_data, interp_data, last_smp;
    int miscompares = 0;
    int num_checks = 0;
    int smp_cnt = 0;
    int lows;
    always #50 i_clk = ~i_clk;
    afc_host_model i_afc_host_model (.i_clk(i_clk), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .i_reg_rdata(reg_rdata));
    afc_filter_chain i_afc_filter_chain (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .i_adc_valid(adc_valid),
        .i_adc_axis(adc_axis), .i_adc_data(adc_data), .i_overrange(overrange),
        .i_ext_sync(ext_sync), .o_drive_clk_en(drive_en), .o_self_test_mode(st_mode),
        .o_self_test_force(st_force), .o_smp_valid(smp_valid), .o_smp_axis(smp_axis),
        .o_smp_data(smp_data), .o_interp_valid(interp_valid), .o_interp_data(interp_data));
    always @(posedge i_clk) begin
        if (smp_valid === 1'b1) begin
            smp_cnt <= smp_cnt + 1;
            last_smp <= smp_data;
        end
    end
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one 20-bit converter sample every other cycle
    task automatic send(input logic [1:0] ax, input logic [19:0] d, input int n);
        repeat (n) begin
            @(posedge i_clk);
            adc_valid <= 1'b1;
            adc_axis <= ax;
            adc_data <= d;
            @(posedge i_clk);
            adc_valid <= 1'b0;
            adc_data <= ~d;
        end
        repeat (12) @(posedge i_clk);
        #1;
    endtask
    task automatic t_reset();
        i_afc_host_model.rd(AFC_FILTER_SETTINGS_OFFSET, rv);
        chk({12'h0, rv}, 20'h00000);
        i_afc_host_model.rd(AFC_SELF_TEST_CONTROL_OFFSET, rv);
        chk({12'h0, rv}, 20'h00000);
        chk({17'h0, drive_en, st_mode, st_force}, 20'h00004);
        $display("test reset done");
    endtask
    task automatic t_regs();
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'hff);
        i_afc_host_model.rd(AFC_FILTER_SETTINGS_OFFSET, rv);
        chk({12'h0, rv}, 20'h0007f);
        i_afc_host_model.wr(8'h10, 8'h55);
        i_afc_host_model.rd(8'h10, rv);
        chk({12'h0, rv}, 20'h00000);
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'h00);
        $display("test registers done");
    endtask
    task automatic t_selftest();
        i_afc_host_model.wr(AFC_SELF_TEST_CONTROL_OFFSET, 8'hfd);
        i_afc_host_model.rd(AFC_SELF_TEST_CONTROL_OFFSET, rv);
        chk({12'h0, rv}, 20'h00001);
        chk({18'h0, st_mode, st_force}, 20'h00002);
        i_afc_host_model.wr(AFC_SELF_TEST_CONTROL_OFFSET, 8'h02);
        @(posedge i_clk);
        #1 chk({18'h0, st_mode, st_force}, 20'h00000);
        i_afc_host_model.wr(AFC_SELF_TEST_CONTROL_OFFSET, 8'h03);
        @(posedge i_clk);
        #1 chk({18'h0, st_mode, st_force}, 20'h00003);
        send(2'h2, 20'h00100, 4);
        chk(last_smp, 20'h00100 + AFC_ST_RESPONSE);
        chk({18'h0, smp_axis}, 20'h00002);
        i_afc_host_model.st_off();
        @(posedge i_clk);
        #1 chk({18'h0, st_mode, st_force}, 20'h00000);
        $display("test self test done");
    endtask
    task automatic t_rates();
        int c0;
        c0 = smp_cnt;
        send(2'h0, 20'h00100, 8);
        chk(20'(smp_cnt - c0), 20'h00002);
        chk(last_smp, 20'h00100);
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'h02);
        c0 = smp_cnt;
        send(2'h1, 20'h00100, 32);
        chk(20'(smp_cnt - c0), 20'h00002);
        chk(last_smp, 20'h00100);
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'h00);
        $display("test rates done");
    endtask
    task automatic t_overrange();
        int c0;
        c0 = smp_cnt;
        lows = 0;
        @(posedge i_clk);
        overrange <= 1'b1;
        @(posedge i_clk);
        overrange <= 1'b0;
        fork
            repeat (5100) begin
                @(posedge i_clk);
                #1 if (drive_en === 1'b0) lows++;
            end
            send(2'h0, 20'h00100, 4);
        join
        chk({19'h0, lows >= 4995 && lows <= 5001}, 20'h00001);
        chk(20'(smp_cnt - c0), 20'h00001);
        chk(last_smp, 20'h00000);
        $display("test overrange done");
    endtask
    task automatic t_highpass();
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'h10);
        send(2'h0, 20'h00100, 1200);
        chk({19'h0, last_smp < 20'sh00040 && last_smp > -20'sh00040}, 20'h00001);
        $display("test highpass done");
    endtask
    // two equal samples with the high pass off leave a flat ramp to read back
    task automatic t_interp();
        i_afc_host_model.wr(AFC_FILTER_SETTINGS_OFFSET, 8'h00);
        send(2'h0, 20'h00100, 8);
        repeat (70) @(posedge i_clk);
        #1 chk(20'(interp_valid), 20'h00000);
        @(posedge i_clk);
        ext_sync <= 1'b1;
        @(posedge i_clk);
        ext_sync <= 1'b0;
        #1 chk(20'(interp_valid), 20'h00001);
        chk(interp_data, 20'h00100);
        $display("test interpolation done");
    endtask
    task automatic wrap_up();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        #5_000_000;
        miscompares++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_regs();
        t_selftest();
        t_rates();
        t_overrange();
        t_highpass();
        t_interp();
        wrap_up();
    end
endmodule
`default_nettype wire
